// ==== gpp_consts.svh ====
// Offsets, field positions, reset values and timing counts of the port block
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
// ***********************************************
// Register offsets (byte addresses)
// ***********************************************
`define GPP_OFF_DIR 12'h400
`define GPP_OFF_ISENSE 12'h404
`define GPP_OFF_IBOTH 12'h408
`define GPP_OFF_IEVENT 12'h40c
`define GPP_OFF_IMASK 12'h410
`define GPP_OFF_RIS 12'h414
`define GPP_OFF_MIS 12'h418
`define GPP_OFF_ICLR 12'h41c
`define GPP_OFF_AFSEL 12'h420
`define GPP_OFF_DR2 12'h500
`define GPP_OFF_DR4 12'h504
`define GPP_OFF_DR8 12'h508
`define GPP_OFF_ODR 12'h50c
`define GPP_OFF_PUR 12'h510
`define GPP_OFF_PDR 12'h514
`define GPP_OFF_SLR 12'h518
`define GPP_OFF_DEN 12'h51c
`define GPP_OFF_PCTL 12'h52c
// Data window: address bits 11:10 zero, bits 9:2 are the bit mask
`define GPP_DATA_MSB 11
`define GPP_MASK_MSB 9
`define GPP_MASK_LSB 2
`define GPP_PCTL_W 4
// ***********************************************
// Per-port implemented bits and reset values
// ***********************************************
`define GPP_A_IMPL 8'h3f
`define GPP_A_AFSEL 8'h3f
`define GPP_A_PUR 8'h00
`define GPP_A_PCTL 32'h0011_1111
`define GPP_B_IMPL 8'hff
`define GPP_B_AFSEL 8'h8c
`define GPP_B_PUR 8'h80
`define GPP_B_PCTL 32'h3000_1100
`define GPP_B_ADC 8'h10
`define GPP_C_IMPL 8'hff
`define GPP_C_AFSEL 8'h0f
`define GPP_C_PUR 8'h0f
`define GPP_C_PCTL 32'h0000_3333
`define GPP_D_IMPL 8'h0f
`define GPP_E_IMPL 8'h03
// Fastest output toggle, in system clock cycles
`define GPP_TOGGLE_CYC 2
`endif

// ==== gpp_pad_model.sv ====
// Pad and board model that resolves the level seen on each port pin
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_model (
  input wire logic core_clk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] padPullUp,
  input wire logic [7:0] padPullDown,
  input wire logic [7:0] extLevel,
  input wire logic [7:0] extEn,
  output logic [7:0] pinLevel
);
  // A floating pin wanders, so a stale value can never pass for a real one
  logic [7:0] floatPat = 8'h55;
  always @(posedge core_clk) begin
    floatPat <= ~floatPat;
  end
  // Port driver wins, then the board, then the weak pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (extEn[i]) pinLevel[i] = extLevel[i];
      else if (padPullUp[i]) pinLevel[i] = 1'b1;
      else if (padPullDown[i]) pinLevel[i] = 1'b0;
      else pinLevel[i] = floatPat[i];
    end
  end
endmodule : gpp_pad_model
`default_nettype wire

// ==== gpp_pkg.sv ====
// Types shared by the port block and its input synchroniser
package gpp_pkg;
  // Whole state of one port
  typedef struct packed {
    logic [7:0] pinDirection;
    logic [7:0] pinValueRegister;
    logic [7:0] isLevel;
    logic [7:0] bothEdges;
    logic [7:0] eventHigh;
    logic [7:0] irqMask;
    logic [7:0] rawIrq;
    logic [7:0] altFunctionSelect;
    logic [7:0] drive2;
    logic [7:0] drive4;
    logic [7:0] drive8;
    logic [7:0] openDrain;
    logic [7:0] pullupEnable;
    logic [7:0] pulldownEnable;
    logic [7:0] slewCtl;
    logic [7:0] digitalEnableBit;
    logic [7:0] prevIn;
    logic [31:0] portFunctionControl;
    logic [31:0] rdata;
  } gpp_state_t;
  // Three-stage synchroniser state
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] clean;
  } gpp_sync_t;
endpackage : gpp_pkg

// ==== gpp_port.sv ====
// One general-purpose I/O port: registers, pin muxing, pad controls, pin events
//
// What this block does
// - Direction 0: pin is an input and its data bit shows the pin level.
// - Direction 1: pin is an output driven from its data bit.
// - After reset ordinary pins are GPIO, tri-stated, function and pad fields zero except 2 mA drive set.
// - Reset returns every pin to its default, whatever software configured.
// - Serial, SPI and I2C pins reset to function 1; debug pins to function 3 with pull-up.
// - Debug pins default to their debug function; port B bit 7 to test reset.
// - Other pins leave reset as inputs with alternate function off.
// - Digital enable cleared selects analog use and cuts the digital input.
// - Alternate function drives a pin only with select and digital enable set.
// - Each pin's function choice is independent of every other pin.
// - Output pins can change as often as every two clocks.
// - Edge events, rising, falling or both, raise maskable interrupts.
// - Level events, high or low, raise interrupts instead.
// - Data register accesses are bit-masked by address lines.
// - A port pin can trigger the converter's sample sequence.
// - All five ports use this block, differing only in bits and defaults.
// - Pads have pulls, 2/4/8 mA drive, slew at 8 mA, open drain, input enable.
// - Data write changes only bits whose address bit 9:2 is one.
// - Data read returns zero for bits whose address bit is zero.
// - All pin events of the port merge into one interrupt output.
`timescale 1ns/1ns
`default_nettype none
`include "gpp_consts.svh"
module gpp_port #(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] RST_AFSEL = 8'h00,
  parameter logic [7:0] RST_PUR = 8'h00,
  parameter logic [31:0] RST_PCTL = 32'h0000_0000,
  parameter logic [7:0] ADC_MASK = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  input wire logic [7:0][15:0] altOut,
  input wire logic [7:0][15:0] altOe,
  output logic [7:0] periphIn,
  output logic [7:0] analogEnable,
  output logic [7:0] padPullUp,
  output logic [7:0] padPullDown,
  output logic [7:0] padDrive2,
  output logic [7:0] padDrive4,
  output logic [7:0] padDrive8,
  output logic [7:0] padSlew,
  output logic [7:0] padOpenDrain,
  output logic portIrq,
  output logic adcTrigger
);
  import gpp_pkg::*;

  // Reset image: digital enable follows the alternate-function default
  localparam gpp_state_t RST_ST = '{altFunctionSelect: RST_AFSEL & IMPL,
    digitalEnableBit: RST_AFSEL & IMPL, pullupEnable: RST_PUR & IMPL,
    portFunctionControl: RST_PCTL, drive2: IMPL, default: '0};

  gpp_state_t st;
  gpp_state_t next_st;
  logic [7:0] cleanIn;
  logic [7:0] inLive;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] edgeHit;
  logic [7:0] levelHit;
  logic [7:0] altSel;
  logic [7:0] altEn;
  logic [7:0] srcOut;
  logic [7:0] srcOe;
  logic [7:0] wb;
  logic [7:0] rv;
  logic [7:0] amask;
  logic inData;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : hit

  // ***********************************************
  // Inputs, events and function routing
  // ***********************************************
  gpp_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .rawIn(pinIn),
    .cleanIn(cleanIn)
  );

  // Analog pins see no digital input at all; missing bits stay zero
  assign inLive = cleanIn & st.digitalEnableBit & IMPL;
  assign rise = inLive & ~st.prevIn;
  assign fall = ~inLive & st.prevIn;
  assign edgeHit = (st.bothEdges & (rise | fall))
    | (~st.bothEdges & st.eventHigh & rise)
    | (~st.bothEdges & ~st.eventHigh & fall);
  assign levelHit = ~(inLive ^ st.eventHigh) & IMPL;

  // Per-pin function mux; code 0 selects entry 0 of the peripheral table like any other code
  for (genvar i = 0; i < 8; i++) begin : g_alt
    assign altSel[i] = altOut[i][st.portFunctionControl[4*i +: `GPP_PCTL_W]];
    assign altEn[i] = altOe[i][st.portFunctionControl[4*i +: `GPP_PCTL_W]];
  end

  assign inData = regAddr[`GPP_DATA_MSB:`GPP_MASK_MSB + 1] == 2'b00;
  assign amask = regAddr[`GPP_MASK_MSB:`GPP_MASK_LSB];
  assign wb = regWdata[7:0];

  // ***********************************************
  // Register file and next state
  // ***********************************************
  always_comb begin
    next_st = st;
    next_st.prevIn = inLive;
    next_st.rdata = '0;
    rv = 8'h00;
    // Read mux; inputs show the synchronised pin, outputs the stored value
    if (regRd) begin
      if (inData) begin
        rv = ((st.pinDirection & st.pinValueRegister)
          | (~st.pinDirection & inLive)) & amask;
      end else begin
        unique case (regAddr)
          `GPP_OFF_DIR: rv = st.pinDirection;
          `GPP_OFF_ISENSE: rv = st.isLevel;
          `GPP_OFF_IBOTH: rv = st.bothEdges;
          `GPP_OFF_IEVENT: rv = st.eventHigh;
          `GPP_OFF_IMASK: rv = st.irqMask;
          `GPP_OFF_RIS: rv = st.rawIrq;
          `GPP_OFF_MIS: rv = st.rawIrq & st.irqMask;
          `GPP_OFF_AFSEL: rv = st.altFunctionSelect;
          `GPP_OFF_DR2: rv = st.drive2;
          `GPP_OFF_DR4: rv = st.drive4;
          `GPP_OFF_DR8: rv = st.drive8;
          `GPP_OFF_ODR: rv = st.openDrain;
          `GPP_OFF_PUR: rv = st.pullupEnable;
          `GPP_OFF_PDR: rv = st.pulldownEnable;
          `GPP_OFF_SLR: rv = st.slewCtl;
          `GPP_OFF_DEN: rv = st.digitalEnableBit;
          default: rv = 8'h00;
        endcase
      end
      next_st.rdata = hit(regAddr, `GPP_OFF_PCTL) ? st.portFunctionControl
        : {24'h000000, rv & IMPL};
    end
    // Event latch: level bits follow the pin, edge bits stick until cleared
    next_st.rawIrq = ((st.isLevel & levelHit)
      | (~st.isLevel & (st.rawIrq | edgeHit))) & IMPL;
    if (regWr) begin
      if (inData) begin
        next_st.pinValueRegister = ((st.pinValueRegister & ~amask)
          | (wb & amask)) & IMPL;
      end else begin
        unique case (regAddr)
          `GPP_OFF_DIR: next_st.pinDirection = wb & IMPL;
          `GPP_OFF_ISENSE: next_st.isLevel = wb & IMPL;
          `GPP_OFF_IBOTH: next_st.bothEdges = wb & IMPL;
          `GPP_OFF_IEVENT: next_st.eventHigh = wb & IMPL;
          `GPP_OFF_IMASK: next_st.irqMask = wb & IMPL;
          // A new edge in the clear cycle survives the clear
          `GPP_OFF_ICLR: next_st.rawIrq = ((st.isLevel & levelHit)
            | (~st.isLevel & ((st.rawIrq & ~wb) | edgeHit))) & IMPL;
          `GPP_OFF_AFSEL: next_st.altFunctionSelect = wb & IMPL;
          // Drive strengths are one-hot per pin: setting one drops the others
          `GPP_OFF_DR2: begin
            next_st.drive2 = (st.drive2 | wb) & IMPL;
            next_st.drive4 = st.drive4 & ~wb;
            next_st.drive8 = st.drive8 & ~wb;
          end
          `GPP_OFF_DR4: begin
            next_st.drive4 = (st.drive4 | wb) & IMPL;
            next_st.drive2 = st.drive2 & ~wb;
            next_st.drive8 = st.drive8 & ~wb;
          end
          `GPP_OFF_DR8: begin
            next_st.drive8 = (st.drive8 | wb) & IMPL;
            next_st.drive2 = st.drive2 & ~wb;
            next_st.drive4 = st.drive4 & ~wb;
          end
          `GPP_OFF_ODR: next_st.openDrain = wb & IMPL;
          `GPP_OFF_PUR: next_st.pullupEnable = wb & IMPL;
          `GPP_OFF_PDR: next_st.pulldownEnable = wb & IMPL;
          `GPP_OFF_SLR: next_st.slewCtl = wb & IMPL;
          `GPP_OFF_DEN: next_st.digitalEnableBit = wb & IMPL;
          `GPP_OFF_PCTL: next_st.portFunctionControl = regWdata;
          default: ;
        endcase
      end
    end
  end

  // State register; reset restores each instance's own defaults
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ***********************************************
  // Pin and pad outputs
  // ***********************************************
  // Write lands in one cycle, so back-to-back writes toggle faster than required
  // Selection is bit by bit, so one pin's function never moves another pin
  assign srcOut = (st.altFunctionSelect & altSel)
    | (~st.altFunctionSelect & st.pinValueRegister);
  assign srcOe = (st.altFunctionSelect & altEn)
    | (~st.altFunctionSelect & st.pinDirection);
  // Open drain only ever pulls low
  assign pinOut = srcOut & ~st.openDrain & IMPL;
  assign pinOe = srcOe & st.digitalEnableBit & (~st.openDrain | ~srcOut) & IMPL;
  assign periphIn = inLive & st.altFunctionSelect;
  assign analogEnable = ~st.digitalEnableBit & IMPL;
  assign padPullUp = st.pullupEnable;
  assign padPullDown = st.pulldownEnable;
  assign padDrive2 = st.drive2;
  assign padDrive4 = st.drive4;
  assign padDrive8 = st.drive8;
  assign padSlew = st.slewCtl & st.drive8;
  assign padOpenDrain = st.openDrain;
  assign portIrq = |(st.rawIrq & st.irqMask);
  assign adcTrigger = |(st.rawIrq & st.irqMask & ADC_MASK);
  assign regRdata = st.rdata;

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  rd_mask_zero_a: assert property (regRd && inData |=>
    (regRdata[7:0] & ~$past(amask)) == 8'h00)
    else $error("masked data bit read nonzero");
  wr_mask_keep_a: assert property (regWr && inData |=>
    ((st.pinValueRegister ^ $past(st.pinValueRegister)) & ~$past(amask)) == 8'h00)
    else $error("unmasked data bit changed");
  wr_mask_take_a: assert property (regWr && inData |=>
    (st.pinValueRegister & $past(amask)) == ($past(wb & amask) & IMPL))
    else $error("masked write not taken");
  gpio_drive_a: assert property (((~st.altFunctionSelect & st.pinDirection
    & st.digitalEnableBit & ~st.openDrain & IMPL) & (pinOut ^ st.pinValueRegister))
    == 8'h00)
    else $error("output pin not driven from data");
  input_float_a: assert property ((pinOe & ~st.altFunctionSelect
    & ~st.pinDirection) == 8'h00)
    else $error("input pin driven");
  reset_default_a: assert property ($past(rst) |-> st.altFunctionSelect ==
    (RST_AFSEL & IMPL) && st.portFunctionControl == RST_PCTL
    && st.pinDirection == 8'h00)
    else $error("reset defaults wrong");
  edge_latch_a: assert property (|(edgeHit & ~st.isLevel) |=>
    (st.rawIrq & $past(edgeHit & ~st.isLevel)) == $past(edgeHit & ~st.isLevel & IMPL))
    else $error("edge event lost");
  edge_hold_a: assert property (regWr && hit(regAddr, `GPP_OFF_ICLR) |=>
    (st.rawIrq & ~$past(st.isLevel)) ==
    ($past((st.rawIrq & ~wb) | edgeHit) & ~$past(st.isLevel) & IMPL))
    else $error("edge clear wrong");
  level_follow_a: assert property (##1 ((st.rawIrq ^ $past(levelHit))
    & $past(st.isLevel)) == 8'h00)
    else $error("level event does not follow pin");
  irq_merge_a: assert property (portIrq == |(st.rawIrq & st.irqMask)
    && (portIrq || !adcTrigger))
    else $error("port interrupt wrong");
  analog_cut_a: assert property ((periphIn & ~st.digitalEnableBit) == 8'h00)
    else $error("analog pin feeds digital input");
  nopin_zero_a: assert property (((st.pinDirection | st.rawIrq | pinOe) & ~IMPL)
    == 8'h00)
    else $error("missing bit active");

  // Per-pin routing, pad drive and read-idle checks
  alt_pin_a: assert property (((st.altFunctionSelect & ~st.openDrain & IMPL)
    & (pinOut ^ altSel)) == 8'h00)
    else $error("alternate output not routed per pin");
  analog_drive_a: assert property ((pinOe & ~st.digitalEnableBit) == 8'h00)
    else $error("analog pin driven");
  drive_onehot_a: assert property (((padDrive2 & padDrive4) | (padDrive2 & padDrive8)
    | (padDrive4 & padDrive8)) == 8'h00)
    else $error("two drive strengths on one pin");
  data_out_a: assert property (regWr && inData |=> ((pinOut ^ st.pinValueRegister)
    & st.pinDirection & ~st.altFunctionSelect & st.digitalEnableBit & ~st.openDrain & IMPL) == 8'h00)
    else $error("data write late on pin");
  rdata_idle_a: assert property (!regRd |=> regRdata == 32'h0000_0000)
    else $error("read data without a read");

  // Main scenarios the bench should reach
  edge_irq_c: cover property (|(edgeHit & st.irqMask & ~st.isLevel) ##1 portIrq);
  level_irq_c: cover property (|(levelHit & st.isLevel & st.irqMask) ##1 portIrq);
  alt_drive_c: cover property (|(pinOe & st.altFunctionSelect));
  masked_wr_c: cover property (regWr && inData && amask != 8'hff && amask != 8'h00);
  toggle_c: cover property (pinOut[0] ##2 !pinOut[0] ##2 pinOut[0]);
endmodule : gpp_port
`default_nettype wire

// ==== gpp_port_test.sv ====
// Self-checking bench for one port instance set up as port B
`timescale 1ns/1ns
`default_nettype none
`include "gpp_consts.svh"
module gpp_port_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata, rdv;
  logic [7:0] pinIn, pinOut, pinOe, periphIn, analogEnable, padPullUp, padPullDown;
  logic [7:0] padDrive2, padDrive4, padDrive8, padSlew, padOpenDrain, model, m8, d8;
  logic [7:0] extLevel = 8'h00;
  logic [7:0] extEn = 8'hff;
  logic portIrq, adcTrigger;
  logic [7:0][15:0] altOut, altOe;
  integer seed = 32'hde44;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  gpp_port #(.IMPL(`GPP_B_IMPL), .RST_AFSEL(`GPP_B_AFSEL), .RST_PUR(`GPP_B_PUR),
    .RST_PCTL(`GPP_B_PCTL), .ADC_MASK(`GPP_B_ADC)) u_dut (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut),
    .altOe(altOe), .periphIn(periphIn), .analogEnable(analogEnable), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .padDrive2(padDrive2), .padDrive4(padDrive4),
    .padDrive8(padDrive8), .padSlew(padSlew), .padOpenDrain(padOpenDrain),
    .portIrq(portIrq), .adcTrigger(adcTrigger));
  gpp_pad_model u_pads (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
    .padPullUp(padPullUp), .padPullDown(padPullDown), .extLevel(extLevel), .extEn(extEn),
    .pinLevel(pinIn));
  // ***********************************************
  // Clock, watchdog and reporting
  // ***********************************************
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // The whole run needs about 300 cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      final_report();
    end
  end
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ***********************************************
  // Register bus master and expectations
  // ***********************************************
  // One-cycle strobes; a later call always waits a fresh edge
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask : rd
  function automatic logic [7:0] wrMask(logic [7:0] old, logic [7:0] d, logic [11:0] a);
    return (old & ~a[9:2]) | (d & a[9:2]);
  endfunction : wrMask
  // Input pin settles after the synchroniser; give it six edges
  task pinStep(input logic lvl, input logic expIrq);
    extLevel[4] <= lvl;
    repeat (6) @(posedge core_clk);
    #1 chk("portIrq", 32'(portIrq), 32'(expIrq));
  endtask : pinStep
  task resetCheck();
    rd(`GPP_OFF_DIR); chk("dir", rdv, 32'h0);
    rd(`GPP_OFF_AFSEL); chk("afsel", rdv, 32'h8c);
    rd(`GPP_OFF_DEN); chk("den", rdv, 32'h8c);
    rd(`GPP_OFF_PUR); chk("pur", rdv, 32'h80);
    rd(`GPP_OFF_PDR); chk("pdr", rdv, 32'h0);
    rd(`GPP_OFF_PCTL); chk("pctl", rdv, 32'h3000_1100);
    chk("pullUp", 32'(padPullUp), 32'h80);
    chk("tristate", 32'(pinOe & 8'h73), 32'h0);
    $display("test reset done");
  endtask : resetCheck
  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    for (int i = 0; i < 8; i++) begin
      altOut[i] = 16'($random(seed));
      altOe[i] = 16'($random(seed));
    end
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    resetCheck();
    // Masked data writes and reads, the documented example first
    wr(`GPP_OFF_DIR, 32'hff); wr(`GPP_OFF_AFSEL, 32'h0); wr(`GPP_OFF_DEN, 32'hff);
    wr(12'h3fc, 32'h0);
    model = wrMask(8'h00, 8'heb, 12'h098);
    wr(12'h098, 32'heb);
    rd(12'h3fc); chk("dataWr", rdv, 32'(model));
    rd(12'h0c4); chk("dataRd", rdv, 32'(model & 8'h31));
    for (int k = 0; k < 24; k++) begin
      m8 = 8'($random(seed));
      d8 = 8'($random(seed));
      model = wrMask(model, d8, {2'b00, m8, 2'b00});
      wr({2'b00, m8, 2'b00}, 32'(d8));
      #1 chk("pinOut", 32'(pinOut), 32'(model));
      m8 = 8'($random(seed));
      rd({2'b00, m8, 2'b00}); chk("dataMask", rdv, 32'(model & m8));
    end
    wr(12'h7fc, 32'hff); rd(12'h7fc); chk("unmapped", rdv, 32'h0);
    $display("test data done");
    // Input capture through the synchroniser, then analog use
    wr(`GPP_OFF_DIR, 32'h0);
    repeat (6) @(posedge core_clk);
    extLevel <= 8'($random(seed)) | 8'h01;
    rd(12'h3fc); chk("syncDelay", rdv, 32'h0);
    repeat (6) @(posedge core_clk);
    rd(12'h3fc); chk("pinRead", rdv, 32'(extLevel));
    wr(`GPP_OFF_AFSEL, 32'hff);
    #1 chk("periphIn", 32'(periphIn), 32'(extLevel));
    wr(`GPP_OFF_DEN, 32'h0);
    rd(12'h3fc); chk("analogRd", rdv, 32'h0);
    chk("analogEn", 32'(analogEnable), 32'hff);
    chk("periphCut", 32'(periphIn), 32'h0);
    wr(`GPP_OFF_DEN, 32'hff);
    $display("test input done");
    // Alternate function on pin 0 only
    wr(`GPP_OFF_DIR, 32'hff); wr(`GPP_OFF_AFSEL, 32'h01); wr(`GPP_OFF_PCTL, 32'h5);
    #1 chk("altOut", 32'(pinOut[0]), 32'(altOut[0][5]));
    chk("altOe", 32'(pinOe[0]), 32'(altOe[0][5]));
    chk("otherPins", 32'(pinOut[7:1]), 32'(model[7:1]));
    wr(`GPP_OFF_DEN, 32'hfe);
    #1 chk("altNoDen", 32'(pinOe[0]), 32'h0);
    wr(`GPP_OFF_AFSEL, 32'h0); wr(`GPP_OFF_DEN, 32'hff);
    // Pad controls
    wr(`GPP_OFF_DR8, 32'h01); wr(`GPP_OFF_DR4, 32'h02);
    wr(`GPP_OFF_SLR, 32'h03); wr(`GPP_OFF_PDR, 32'hf0);
    #1 chk("drive8", 32'(padDrive8), 32'h01);
    chk("drive4", 32'(padDrive4), 32'h02);
    chk("drive2", 32'(padDrive2), 32'hfc);
    chk("slew", 32'(padSlew), 32'h01);
    chk("pullDown", 32'(padPullDown), 32'hf0);
    // Open drain on pin 1: never drives high, enables only to pull low
    wr(`GPP_OFF_ODR, 32'h02);
    #1 chk("openDrain", 32'(padOpenDrain), 32'h02);
    chk("odOe", 32'(pinOe[1]), 32'(!model[1]));
    chk("odOut", 32'(pinOut[1]), 32'h0);
    wr(`GPP_OFF_ODR, 32'h0);
    $display("test alt and pads done");
    // Pin 4 events: rising, falling, both, mask, then levels
    wr(`GPP_OFF_DIR, 32'h0);
    extLevel <= 8'h00;
    // Clear only after the pins' last changes have passed the synchroniser
    wr(`GPP_OFF_IEVENT, 32'h10); wr(`GPP_OFF_IMASK, 32'h10); wr(`GPP_OFF_ICLR, 32'hff);
    pinStep(1'b0, 1'b0);
    pinStep(1'b1, 1'b1);
    chk("adcTrig", 32'(adcTrigger), 32'h1);
    pinStep(1'b0, 1'b1);
    wr(`GPP_OFF_ICLR, 32'h10); wr(`GPP_OFF_IEVENT, 32'h0);
    #1 chk("cleared", 32'(portIrq), 32'h0);
    pinStep(1'b1, 1'b0);
    pinStep(1'b0, 1'b1);
    wr(`GPP_OFF_IBOTH, 32'h10); wr(`GPP_OFF_ICLR, 32'h10);
    pinStep(1'b1, 1'b1);
    wr(`GPP_OFF_ICLR, 32'h10);
    pinStep(1'b0, 1'b1);
    wr(`GPP_OFF_IMASK, 32'h0);
    #1 chk("masked", 32'(portIrq), 32'h0);
    rd(`GPP_OFF_RIS); chk("ris", rdv, 32'h10);
    rd(`GPP_OFF_MIS); chk("mis", rdv, 32'h0);
    wr(`GPP_OFF_ISENSE, 32'h10); wr(`GPP_OFF_IBOTH, 32'h0);
    wr(`GPP_OFF_IEVENT, 32'h10); wr(`GPP_OFF_IMASK, 32'h10);
    pinStep(1'b1, 1'b1);
    pinStep(1'b0, 1'b0);
    wr(`GPP_OFF_IEVENT, 32'h0);
    pinStep(1'b0, 1'b1);
    $display("test events done");
    // Reset in mid-run returns every default
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("irqAfterRst", 32'(portIrq), 32'h0);
    resetCheck();
    final_report();
  end
endmodule : gpp_port_test
`default_nettype wire

// ==== gpp_sync.sv ====
// Three-flop synchroniser for the port's pin inputs
`timescale 1ns/1ns
`default_nettype none
module gpp_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] rawIn,
  output logic [7:0] cleanIn
);
  import gpp_pkg::*;
  gpp_sync_t st;
  gpp_sync_t next_st;
  logic [7:0] agree;

  // Stage one feeds only stage two; a change counts once stages two and three agree
  always_comb begin
    agree = ~(st.s2 ^ st.s3);
    next_st.s1 = rawIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.clean = (agree & st.s3) | (~agree & st.clean);
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cleanIn = st.clean;
endmodule : gpp_sync
`default_nettype wire
